// ### common/ccr_map.svh
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// register offsets on the microport
`define CCR_OFS_FGAIN   3'h0
`define CCR_OFS_STGAIN  3'h1
`define CCR_OFS_PATH    3'h2
`define CCR_OFS_CTL1    3'h3
`define CCR_OFS_CTL2    3'h4
`define CCR_OFS_CSLOT   3'h5
`define CCR_OFS_SSLOT   3'h6
`define CCR_OFS_LOOP    3'h7

// reset values
`define CCR_RST_FGAIN   8'h80
`define CCR_RST_STGAIN  3'h0
`define CCR_RST_PATH    1'h0
`define CCR_RST_CTL1    8'h00
`define CCR_RST_CTL2    8'h02
`define CCR_RST_SLOTTX  8'hFF
`define CCR_RST_LOOP    2'h0

// writable bits of the power mute select register
`define CCR_MSK_CTL1    8'hEF

// field positions, filter gain register
`define CCR_B_RXBOOST   7
`define CCR_B_TXBOOST   3
// field positions, power mute select register
`define CCR_B_IFPD      7
`define CCR_B_DRPD      6
`define CCR_B_SRST      5
`define CCR_B_TXSIL     3
`define CCR_B_RXSIL     2
`define CCR_B_TXSLOT    1
`define CCR_B_RXSLOT    0
// field positions, format clock register
`define CCR_B_CSLEN     7
`define CCR_B_SSLEN     6
`define CCR_B_SRATE     5
`define CCR_B_ALAW      4
`define CCR_B_FMT       3

// clock rate codes and rates in kHz
`define CCR_CSL_BP      3'h7
`define CCR_CSL_128     3'h4
`define CCR_CSL_256     3'h5
`define CCR_KHZ_128     13'h0080
`define CCR_KHZ_256     13'h0100
`define CCR_KHZ_512     13'h0200
`define CCR_KHZ_1536    13'h0600
`define CCR_KHZ_2048    13'h0800
`define CCR_KHZ_4096    13'h1000

// gains: whole dB, tenths of dB, sidetone steps from code 4
`define CCR_DRV_LOW_DB  5'h1A
`define CCR_EAR_SEL_DB  5'h1A
`define CCR_TXA_HI_TDB  8'h99
`define CCR_TXA_LO_TDB  8'h3C
`define CCR_ST_MID      4'h4

// backplane channel numbers
`define CCR_CH_SIG      2'h0
`define CCR_CH_CTRL     2'h1
`define CCR_CH_B1       2'h2
`define CCR_CH_B2       2'h3

`endif

// ### common/ccr_pkg.sv
package ccr_pkg;

   // serial interface framing mode
   typedef enum logic [1:0] {
      CCR_MODE_STROBED   = 2'b01,
      CCR_MODE_BACKPLANE = 2'b10
   } ccr_mode_e;

   // what the serial output carries in the current slot
   typedef enum logic [5:0] {
      CCR_SRC_NONE  = 6'b000001,
      CCR_SRC_PCM   = 6'b000010,
      CCR_SRC_QUIET = 6'b000100,
      CCR_SRC_MZERO = 6'b001000,
      CCR_SRC_CTRL  = 6'b010000,
      CCR_SRC_SIG   = 6'b100000
   } ccr_src_e;

   // whole state of the bank
   typedef struct packed {
      logic [7:0]        fgain;
      logic [2:0]        stgain;
      logic              path;
      logic [7:0]        ctl1;
      logic [7:0]        ctl2;
      logic [7:0]        cslot_tx;
      logic [7:0]        cslot_rx;
      logic [7:0]        sslot_tx;
      logic [7:0]        sslot_rx;
      logic [1:0]        loop;
      logic [2:0]        frame_cnt;
      logic [7:0]        rdata;
      logic              rd_valid;
      logic              func_reset;
      logic              full_pd;
      logic signed [3:0] rx_fg_db;
      logic signed [3:0] tx_fg_db;
      logic signed [4:0] drv_db;
      logic signed [4:0] ear_db;
      logic [7:0]        txa_tdb;
      logic              st_on;
      logic signed [3:0] st_step;
      ccr_mode_e         mode;
      logic              mclk_need;
      logic              rate_ok;
      logic [12:0]       bclk_khz;
      ccr_src_e          src;
      logic              oe_n;
      logic [1:0]        sig_bits;
   } ccr_state_s;

endpackage : ccr_pkg

// ### design/ccr_top.sv
// Notes on behaviour
// - hardware reset pin blocks all function and access
// - soft reset holds all but microport
// - soft reset ends by writing zero or pin
// - any reset restores every control default
// - strobed mode drives output only inside strobe
// - both power-down bits or pin: full power-down
// - filter gain code n: rx -n dB, tx +n dB
// - rx driver boost: 0 dB high, -6 dB low
// - tx amp boost: 15.3 dB high, 6.0 low
// - sidetone code zero off, else 3.32 dB steps
// - earpiece select: -6 dB when set, else 0
// - interface power-down stops interface and codec; strobed output still sends quiet code, backplane floats only the B channel
// - driver power-down: float backplane B channel, minus-zero strobed
// - tx silence sends quiet code, path keeps running
// - rx silence replaces incoming stream with quiet
// - slot select picks B2/B1, backplane only
// - control slot sends register, channel 1 always received
// - signalling slot sends two bits per frame, one with rate bit high
// - signalling rate bit: 8 kb/s high, 16 low
// - law and code format selection
// - clock rate field selects mode and rates
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module ccr_top
   import ccr_pkg::*;
#(
   parameter int CHAN_W = 5
)(
   input  wire logic                sys_clk,
   input  wire logic                resetn,
   input  wire logic                hardware_reset_n,
   input  wire logic                reg_wr_en,
   input  wire logic                reg_rd_en,
   input  wire logic [2:0]          reg_addr,
   input  wire logic [7:0]          reg_wdata,
   output logic      [7:0]          reg_rdata,
   output logic                     reg_rd_valid,
   input  wire logic                frame_start,
   input  wire logic                frame_strobe,
   input  wire logic                slot_valid,
   input  wire logic [CHAN_W-1:0]   slot_channel,
   input  wire logic                ctl_rx_valid,
   input  wire logic [7:0]          ctl_rx_data,
   input  wire logic                sig_rx_valid,
   input  wire logic [1:0]          sig_rx_bits,
   output logic                     function_reset,
   output logic                     full_powerdown,
   output logic                     interface_powerdown,
   output logic                     driver_powerdown,
   output logic [2:0]               rx_filter_gain,
   output logic [2:0]               tx_filter_gain,
   output logic signed [3:0]        rx_filter_gain_db,
   output logic signed [3:0]        tx_filter_gain_db,
   output logic                     rx_driver_boost,
   output logic                     tx_amp_boost,
   output logic signed [4:0]        rx_driver_gain_db,
   output logic [7:0]               tx_amp_gain_tenth_db,
   output logic [2:0]               sidetone_gain,
   output logic                     sidetone_on,
   output logic signed [3:0]        sidetone_step,
   output logic                     earpiece_gain_select,
   output logic signed [4:0]        earpiece_gain_db,
   output logic                     tx_silence,
   output logic                     rx_silence,
   output logic                     tx_slot_select,
   output logic                     rx_slot_select,
   output logic                     control_slot_enable,
   output logic                     signalling_slot_enable,
   output logic                     signalling_rate_half,
   output logic                     alaw_select,
   output logic                     code_format_select,
   output logic [2:0]               clock_rate_select,
   output var ccr_mode_e            serial_mode,
   output logic                     master_clock_needed,
   output logic                     clock_rate_valid,
   output logic [12:0]              bit_clock_khz,
   output logic [1:0]               loop_test_control,
   output var ccr_src_e             serial_out_source,
   output logic                     serial_out_oe_n,
   output logic [7:0]               control_slot_tx_data,
   output logic [1:0]               signalling_tx_bits
);

   if (CHAN_W < 2)
      $error("ccr_top: CHAN_W must be at least 2");

   ////////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   logic rst_meta_q;
   logic rst_sync_q;

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state and next state
   ccr_state_s st_q;
   ccr_state_s st_d;
   ccr_state_s st_rst;

   logic hw_rst;
   logic srst;
   logic [7:0] tx_shift;
   assign hw_rst = ~hardware_reset_n;
   // defaults taken by the hardware reset pin
   always_comb
   begin
      st_rst           = '0;
      st_rst.fgain     = `CCR_RST_FGAIN;
      st_rst.stgain    = `CCR_RST_STGAIN;
      st_rst.path      = `CCR_RST_PATH;
      st_rst.ctl1      = `CCR_RST_CTL1;
      st_rst.ctl2      = `CCR_RST_CTL2;
      st_rst.cslot_tx  = `CCR_RST_SLOTTX;
      st_rst.sslot_tx  = `CCR_RST_SLOTTX;
      st_rst.loop      = `CCR_RST_LOOP;
      st_rst.func_reset = 1'b1;
      st_rst.full_pd   = 1'b1;
      st_rst.mode      = CCR_MODE_STROBED;
      st_rst.rate_ok   = 1'b1;
      st_rst.bclk_khz  = `CCR_KHZ_2048;
      st_rst.txa_tdb   = `CCR_TXA_LO_TDB;
      st_rst.drv_db    = 5'sd0;
      st_rst.st_step   = -4'sd4;
      st_rst.src       = CCR_SRC_NONE;
      st_rst.oe_n      = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // register access, capture and decoded controls
   always_comb
   begin
      tx_shift    = 8'h00;
      srst        = 1'b0;
      st_d        = st_q;
      st_d.rd_valid = 1'b0;
      if (hw_rst)
      begin
         // pin held: defaults, no access; rx bytes are not preset
         st_d          = st_rst;
         st_d.cslot_rx = st_q.cslot_rx;
         st_d.sslot_rx = st_q.sslot_rx;
         st_d.rdata    = st_q.rdata;
      end
      else
      begin
         // writes; reserved bits are stored as zero
         if (reg_wr_en)
         begin
            unique case (reg_addr)
               `CCR_OFS_FGAIN  : st_d.fgain    = reg_wdata;
               `CCR_OFS_STGAIN : st_d.stgain   = reg_wdata[2:0];
               `CCR_OFS_PATH   : st_d.path     = reg_wdata[0];
               `CCR_OFS_CTL1   : st_d.ctl1     = reg_wdata & `CCR_MSK_CTL1;
               `CCR_OFS_CTL2   : st_d.ctl2     = reg_wdata;
               `CCR_OFS_CSLOT  : st_d.cslot_tx = reg_wdata;
               `CCR_OFS_SSLOT  : st_d.sslot_tx = reg_wdata;
               `CCR_OFS_LOOP   : st_d.loop     = reg_wdata[3:2];
            endcase
         end
         // reads return written controls, received slot bytes
         if (reg_rd_en)
         begin
            st_d.rd_valid = 1'b1;
            unique case (reg_addr)
               `CCR_OFS_FGAIN  : st_d.rdata = st_q.fgain;
               `CCR_OFS_STGAIN : st_d.rdata = {5'h00, st_q.stgain};
               `CCR_OFS_PATH   : st_d.rdata = {7'h00, st_q.path};
               `CCR_OFS_CTL1   : st_d.rdata = st_q.ctl1;
               `CCR_OFS_CTL2   : st_d.rdata = st_q.ctl2;
               `CCR_OFS_CSLOT  : st_d.rdata = st_q.cslot_rx;
               `CCR_OFS_SSLOT  : st_d.rdata = st_q.sslot_rx;
               `CCR_OFS_LOOP   : st_d.rdata = {4'h0, st_q.loop, 2'h0};
            endcase
         end
         srst = st_d.ctl1[`CCR_B_SRST];
         if (srst)
         begin
            // only the microport and the reset bit stay alive
            st_d.fgain     = `CCR_RST_FGAIN;
            st_d.stgain    = `CCR_RST_STGAIN;
            st_d.path      = `CCR_RST_PATH;
            st_d.ctl1      = `CCR_RST_CTL1;
            st_d.ctl1[`CCR_B_SRST] = 1'b1;            // not self-clearing
            st_d.ctl2      = `CCR_RST_CTL2;
            st_d.cslot_tx  = `CCR_RST_SLOTTX;
            st_d.sslot_tx  = `CCR_RST_SLOTTX;
            st_d.loop      = `CCR_RST_LOOP;
            st_d.frame_cnt = 3'h0;
         end
         else
         begin
            // channel 1 and channel 0 capture regardless of enables
            if (ctl_rx_valid)
               st_d.cslot_rx = ctl_rx_data;
            if (sig_rx_valid)
            begin
               if (st_q.ctl2[`CCR_B_SRATE])
                  st_d.sslot_rx = {st_q.sslot_rx[6:0], sig_rx_bits[1]};
               else
                  st_d.sslot_rx = {st_q.sslot_rx[5:0], sig_rx_bits};
            end
            if (frame_start)
               st_d.frame_cnt = st_q.frame_cnt + 3'h1;
         end

         // decoded controls from the new register contents
         st_d.func_reset = srst;
         st_d.full_pd    = st_d.ctl1[`CCR_B_IFPD] & st_d.ctl1[`CCR_B_DRPD];
         st_d.rx_fg_db   = -$signed({1'b0, st_d.fgain[6:4]});
         st_d.tx_fg_db   = $signed({1'b0, st_d.fgain[2:0]});
         st_d.drv_db     = st_d.fgain[`CCR_B_RXBOOST] ? 5'sd0 : $signed(`CCR_DRV_LOW_DB);
         st_d.txa_tdb    = st_d.fgain[`CCR_B_TXBOOST] ? `CCR_TXA_HI_TDB : `CCR_TXA_LO_TDB;
         st_d.st_step    = $signed({1'b0, st_d.stgain}) - $signed(`CCR_ST_MID);
         st_d.st_on      = (st_d.stgain != 3'h0) & st_d.path;
         st_d.ear_db     = st_d.path ? $signed(`CCR_EAR_SEL_DB) : 5'sd0;
         // clock rate field decode
         st_d.mclk_need  = 1'b0;
         st_d.rate_ok    = 1'b1;
         st_d.mode       = CCR_MODE_STROBED;
         unique case (st_d.ctl2[2:0])
            3'h0 : st_d.bclk_khz = `CCR_KHZ_512;
            3'h1 : st_d.bclk_khz = `CCR_KHZ_1536;
            3'h2 : st_d.bclk_khz = `CCR_KHZ_2048;
            3'h3 : st_d.bclk_khz = `CCR_KHZ_4096;
            `CCR_CSL_128, `CCR_CSL_256 :
            begin
               st_d.bclk_khz  = st_d.ctl2[0] ? `CCR_KHZ_256 : `CCR_KHZ_128;
               st_d.mclk_need = 1'b1;
            end
            `CCR_CSL_BP :
            begin
               st_d.bclk_khz  = `CCR_KHZ_4096;
               st_d.mode      = CCR_MODE_BACKPLANE;
            end
            default :
            begin
               st_d.bclk_khz  = `CCR_KHZ_2048;
               st_d.rate_ok   = 1'b0;
            end
         endcase

         // signalling bits for the current frame, MSB first
         if (st_d.ctl2[`CCR_B_SRATE])
         begin
            tx_shift      = st_d.sslot_tx << st_d.frame_cnt;
            st_d.sig_bits = {tx_shift[7], 1'b0};
         end
         else
         begin
            tx_shift      = st_d.sslot_tx << {st_d.frame_cnt[1:0], 1'b0};
            st_d.sig_bits = tx_shift[7:6];
         end

         // serial output slot decision, one cycle after slot inputs
         st_d.src  = CCR_SRC_NONE;
         st_d.oe_n = 1'b1;
         if (st_d.mode == CCR_MODE_STROBED)
         begin
            if (frame_strobe && !srst)
            begin
               st_d.oe_n = 1'b0;
               if (st_d.ctl1[`CCR_B_DRPD])
                  st_d.src = CCR_SRC_MZERO;
               else if (st_d.ctl1[`CCR_B_IFPD] | st_d.ctl1[`CCR_B_TXSIL])
                  st_d.src = CCR_SRC_QUIET;
               else
                  st_d.src = CCR_SRC_PCM;
            end
         end
         else if (slot_valid && slot_channel[CHAN_W-1:2] == '0)
         begin
            unique case (slot_channel[1:0])
               `CCR_CH_SIG :
                  if (st_d.ctl2[`CCR_B_SSLEN])
                  begin
                     st_d.src  = CCR_SRC_SIG;
                     st_d.oe_n = 1'b0;
                  end
               `CCR_CH_CTRL :
                  if (st_d.ctl2[`CCR_B_CSLEN])
                  begin
                     st_d.src  = CCR_SRC_CTRL;
                     st_d.oe_n = 1'b0;
                  end
               default :
                  // chosen B channel; power-down leaves it floating
                  if ((slot_channel[0] == st_d.ctl1[`CCR_B_TXSLOT]) &&
                      !st_d.ctl1[`CCR_B_DRPD] && !st_d.ctl1[`CCR_B_IFPD])
                  begin
                     st_d.src  = st_d.ctl1[`CCR_B_TXSIL] ? CCR_SRC_QUIET : CCR_SRC_PCM;
                     st_d.oe_n = 1'b0;
                  end
            endcase
         end
      end
   end

   // the single state register
   always_ff @(posedge sys_clk or negedge rst_sync_q)
   begin
      if (!rst_sync_q)
         st_q <= '{fgain: `CCR_RST_FGAIN, stgain: `CCR_RST_STGAIN, path: `CCR_RST_PATH,
                   ctl1: `CCR_RST_CTL1, ctl2: `CCR_RST_CTL2, cslot_tx: `CCR_RST_SLOTTX,
                   cslot_rx: 8'h00, sslot_tx: `CCR_RST_SLOTTX, sslot_rx: 8'h00,
                   loop: `CCR_RST_LOOP, frame_cnt: 3'h0, rdata: 8'h00, rd_valid: 1'b0,
                   func_reset: 1'b1, full_pd: 1'b1, rx_fg_db: 4'sd0, tx_fg_db: 4'sd0,
                   drv_db: 5'sd0, ear_db: 5'sd0, txa_tdb: `CCR_TXA_LO_TDB, st_on: 1'b0,
                   st_step: -4'sd4, mode: CCR_MODE_STROBED, mclk_need: 1'b0, rate_ok: 1'b1,
                   bclk_khz: `CCR_KHZ_2048, src: CCR_SRC_NONE, oe_n: 1'b1, sig_bits: 2'h0};
      else
         st_q <= st_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from the state register
   assign reg_rdata              = st_q.rdata;
   assign reg_rd_valid           = st_q.rd_valid;
   assign function_reset         = st_q.func_reset;
   assign full_powerdown         = st_q.full_pd;
   assign interface_powerdown    = st_q.ctl1[`CCR_B_IFPD];
   assign driver_powerdown       = st_q.ctl1[`CCR_B_DRPD];
   assign rx_filter_gain         = st_q.fgain[6:4];
   assign tx_filter_gain         = st_q.fgain[2:0];
   assign rx_filter_gain_db      = st_q.rx_fg_db;
   assign tx_filter_gain_db      = st_q.tx_fg_db;
   assign rx_driver_boost        = st_q.fgain[`CCR_B_RXBOOST];
   assign tx_amp_boost           = st_q.fgain[`CCR_B_TXBOOST];
   assign rx_driver_gain_db      = st_q.drv_db;
   assign tx_amp_gain_tenth_db   = st_q.txa_tdb;
   assign sidetone_gain          = st_q.stgain;
   assign sidetone_on            = st_q.st_on;
   assign sidetone_step          = st_q.st_step;
   assign earpiece_gain_select   = st_q.path;
   assign earpiece_gain_db       = st_q.ear_db;
   assign tx_silence             = st_q.ctl1[`CCR_B_TXSIL];
   assign rx_silence             = st_q.ctl1[`CCR_B_RXSIL];
   assign tx_slot_select         = st_q.ctl1[`CCR_B_TXSLOT];
   assign rx_slot_select         = st_q.ctl1[`CCR_B_RXSLOT];
   assign control_slot_enable    = st_q.ctl2[`CCR_B_CSLEN];
   assign signalling_slot_enable = st_q.ctl2[`CCR_B_SSLEN];
   assign signalling_rate_half   = st_q.ctl2[`CCR_B_SRATE];
   assign alaw_select            = st_q.ctl2[`CCR_B_ALAW];
   assign code_format_select     = st_q.ctl2[`CCR_B_FMT];
   assign clock_rate_select      = st_q.ctl2[2:0];
   assign serial_mode            = st_q.mode;
   assign master_clock_needed    = st_q.mclk_need;
   assign clock_rate_valid       = st_q.rate_ok;
   assign bit_clock_khz          = st_q.bclk_khz;
   assign loop_test_control      = st_q.loop;
   assign serial_out_source      = st_q.src;
   assign serial_out_oe_n        = st_q.oe_n;
   assign control_slot_tx_data   = st_q.cslot_tx;
   assign signalling_tx_bits     = st_q.sig_bits;

endmodule : ccr_top

`default_nettype wire

// ### sim/ccr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module ccr_host_model (
   input  wire logic       sys_clk, reg_rd_valid,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr_en, reg_rd_en,
   output logic [2:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   // writable bits of each offset
   logic [7:0] wmask [8];

   // idle bus at time zero
   initial
   begin
      wmask = '{8'hFF, 8'h07, 8'h01, `CCR_MSK_CTL1, 8'hFF, 8'hFF, 8'hFF, 8'h0C};
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
   end

   // one write; address and data lines show junk when idle
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d & wmask[a];
      reg_wr_en = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr_en = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~reg_wdata;
   endtask : wr

   // one read; unknown data comes back if no answer arrives
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      d = 8'hXX;
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd_en = 1'b0;
      reg_addr = ~a;
      for (int i = 0; i < 3; i++)
      begin
         if (reg_rd_valid)
         begin
            d = reg_rdata;
            break;
         end
         @(posedge sys_clk);
         #1;
      end
   endtask : rd
endmodule : ccr_host_model
`default_nettype wire

// ### sim/ccr_top_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module ccr_chk
   import ccr_pkg::*;
(
   input wire logic sys_clk, resetn, hardware_reset_n, reg_wr_en, reg_rd_en, reg_rd_valid,
   input wire logic frame_strobe, function_reset, full_powerdown, interface_powerdown, driver_powerdown,
   input wire logic rx_driver_boost, tx_amp_boost, sidetone_on, earpiece_gain_select, serial_out_oe_n,
   input wire logic [2:0] reg_addr, rx_filter_gain, sidetone_gain, clock_rate_select,
   input wire logic [7:0] reg_wdata, tx_amp_gain_tenth_db,
   input wire logic [12:0] bit_clock_khz,
   input wire logic signed [3:0] rx_filter_gain_db,
   input wire logic signed [4:0] rx_driver_gain_db, earpiece_gain_db,
   input var ccr_mode_e serial_mode
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   // access, reset and power-down
   read_answer_a: assert property (reg_rd_en && hardware_reset_n |=> reg_rd_valid)
      else $error("read not answered");
   pin_block_a: assert property (!hardware_reset_n |=> function_reset && full_powerdown && !reg_rd_valid)
      else $error("pin reset not honoured");
   soft_set_a: assert property (reg_wr_en && hardware_reset_n && reg_addr == 3'h3 && reg_wdata[5] |=> function_reset [*2])
      else $error("soft reset not held");
   soft_clear_a: assert property (reg_wr_en && hardware_reset_n && reg_addr == 3'h3 && !reg_wdata[5] |=> !function_reset)
      else $error("soft reset not removed");
   full_pd_a: assert property (interface_powerdown && driver_powerdown |-> full_powerdown)
      else $error("full power-down missing");
   strobe_float_a: assert property (serial_mode == CCR_MODE_STROBED && !frame_strobe && !reg_wr_en |=> serial_out_oe_n)
      else $error("output driven without strobe");

   // decoded gains and modes
   filter_gain_a: assert property (rx_filter_gain_db == -$signed({1'b0, rx_filter_gain}))
      else $error("filter gain wrong");
   boost_gain_a: assert property (rx_driver_gain_db == (rx_driver_boost ? 5'sh0 : -5'sh6) && tx_amp_gain_tenth_db == (tx_amp_boost ? `CCR_TXA_HI_TDB : `CCR_TXA_LO_TDB))
      else $error("boost gain wrong");
   sidetone_on_a: assert property (sidetone_on == (sidetone_gain != 3'h0 && earpiece_gain_select))
      else $error("sidetone enable wrong");
   ear_gain_a: assert property (earpiece_gain_db == (earpiece_gain_select ? -5'sh6 : 5'sh0))
      else $error("earpiece gain wrong");
   bp_mode_a: assert property (clock_rate_select == 3'h7 |-> serial_mode == CCR_MODE_BACKPLANE && bit_clock_khz == `CCR_KHZ_4096)
      else $error("backplane mode wrong");
endmodule : ccr_chk

bind ccr_top ccr_chk chk_u (.*);
`default_nettype wire

// ### sim/test_codec_control_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "ccr_map.svh"

module test_codec_control_register_bank
   import ccr_pkg::*;
;
   logic sys_clk, resetn, hardware_reset_n, reg_wr_en, reg_rd_en, reg_rd_valid, frame_start, frame_strobe;
   logic slot_valid, ctl_rx_valid, sig_rx_valid, function_reset, full_powerdown, interface_powerdown;
   logic driver_powerdown, rx_driver_boost, tx_amp_boost, sidetone_on, earpiece_gain_select, tx_silence;
   logic rx_silence, tx_slot_select, rx_slot_select, control_slot_enable, signalling_slot_enable;
   logic signalling_rate_half, alaw_select, code_format_select, master_clock_needed, clock_rate_valid;
   logic serial_out_oe_n;
   logic [1:0] sig_rx_bits, loop_test_control, signalling_tx_bits;
   logic [2:0] reg_addr, rx_filter_gain, tx_filter_gain, sidetone_gain, clock_rate_select;
   logic [4:0] slot_channel;
   logic [7:0] reg_wdata, reg_rdata, ctl_rx_data, tx_amp_gain_tenth_db, control_slot_tx_data, rd_data;
   logic [12:0] bit_clock_khz;
   logic signed [3:0] rx_filter_gain_db, tx_filter_gain_db, sidetone_step;
   logic signed [4:0] rx_driver_gain_db, earpiece_gain_db;
   ccr_mode_e serial_mode;
   ccr_src_e serial_out_source;
   int miscompares, samples_checked;

   ccr_top dut_u (.*);
   ccr_host_model host_u (.*);

   // 125 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   // read one offset and compare
   task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
      host_u.rd(a, rd_data);
      chk(rd_data, exp);
   endtask : rchk

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////
   // defaults, then write and read back every register but the two slot offsets
   task automatic t_regs;
      logic [7:0] def [6] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
      logic [2:0] ofs [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
      logic [7:0] wv [6] = '{8'hFF, 8'h07, 8'h01, 8'hCF, 8'hFF, 8'h0C};
      for (int i = 0; i < 6; i++)
         rchk(ofs[i], def[i]);
      chk(serial_mode, CCR_MODE_STROBED);
      for (int i = 0; i < 6; i++)
         host_u.wr(ofs[i], wv[i]);
      for (int i = 0; i < 6; i++)
         rchk(ofs[i], wv[i]);
      chk(full_powerdown, 1'b1);
      host_u.wr(3'h3, 8'h00);
      chk(full_powerdown, 1'b0);
      $display("register test done");
   endtask : t_regs

   // every clock rate code
   task automatic t_clock;
      logic [12:0] khz [8] = '{13'h0200, 13'h0600, 13'h0800, 13'h1000, 13'h0080, 13'h0100, 13'h0800, 13'h1000};
      for (int c = 0; c < 8; c++)
      begin
         host_u.wr(3'h4, 8'(c));
         chk(bit_clock_khz, khz[c]);
         chk(master_clock_needed, c == 4 || c == 5);
         chk(clock_rate_valid, c != 6);
         chk(serial_mode, c == 7 ? CCR_MODE_BACKPLANE : CCR_MODE_STROBED);
      end
      $display("clock test done");
   endtask : t_clock

   // soft reset, then pin reset ending a soft reset
   task automatic t_reset;
      host_u.wr(3'h3, 8'h20);
      chk(function_reset, 1'b1);
      host_u.wr(3'h0, 8'h55);
      rchk(3'h0, 8'h80);
      rchk(3'h4, 8'h02);
      rchk(3'h3, 8'h20);
      host_u.wr(3'h3, 8'h00);
      host_u.wr(3'h0, 8'h55);
      rchk(3'h0, 8'h55);
      host_u.wr(3'h3, 8'h20);
      hardware_reset_n = 1'b0;
      host_u.wr(3'h0, 8'h22);
      chk(full_powerdown, 1'b1);
      hardware_reset_n = 1'b1;
      cyc(1);
      rchk(3'h0, 8'h80);
      rchk(3'h3, 8'h00);
      $display("reset test done");
   endtask : t_reset

   // strobed and backplane output selection
   task automatic t_serial;
      frame_strobe = 1'b1;
      cyc(1);
      chk({serial_out_oe_n, serial_out_source}, {1'b0, CCR_SRC_PCM});
      host_u.wr(3'h3, 8'h08);
      cyc(1);
      chk(serial_out_source, CCR_SRC_QUIET);
      host_u.wr(3'h3, 8'h40);
      cyc(1);
      chk(serial_out_source, CCR_SRC_MZERO);
      frame_strobe = 1'b0;
      cyc(1);
      chk({serial_out_oe_n, serial_out_source}, {1'b1, CCR_SRC_NONE});
      host_u.wr(3'h3, 8'h00);
      host_u.wr(3'h4, 8'h87);
      slot_valid = 1'b1;
      slot_channel = 5'h01;
      cyc(1);
      chk(serial_out_source, CCR_SRC_CTRL);
      slot_channel = 5'h02;
      cyc(1);
      chk(serial_out_source, CCR_SRC_PCM);
      host_u.wr(3'h3, 8'h02);
      cyc(1);
      chk(serial_out_oe_n, 1'b1);
      slot_channel = 5'h03;
      cyc(1);
      chk(serial_out_source, CCR_SRC_PCM);
      slot_valid = 1'b0;
      // received channel 1 bytes and channel 0 dibits
      for (int i = 0; i < 4; i++)
      begin
         {ctl_rx_valid, ctl_rx_data, sig_rx_valid, sig_rx_bits} = {1'b1, 8'(i), 1'b1, 2'(i)};
         cyc(1);
      end
      {ctl_rx_valid, sig_rx_valid} = 2'b00;
      rchk(3'h5, 8'h03);
      rchk(3'h6, 8'h1B);
      $display("serial test done");
   endtask : t_serial

   // watchdog
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      report_and_stop;
   end

   // main sequence
   initial
   begin
      resetn = 1'b0;
      hardware_reset_n = 1'b1;
      {frame_start, frame_strobe, slot_valid, ctl_rx_valid, sig_rx_valid} = '0;
      {slot_channel, ctl_rx_data, sig_rx_bits} = '0;
      miscompares = 0;
      samples_checked = 0;
      cyc(2);
      resetn = 1'b1;
      cyc(3);
      t_regs;
      t_clock;
      t_reset;
      t_serial;
      report_and_stop;
   end
endmodule : test_codec_control_register_bank
`default_nettype wire
